// >>> verilog/tfb_pkg.sv
// Purpose: Constants for the T1 framing-bit data link block
// Assumes: Register index = printed offset, byte address = 4 x index
// Notes:   One framer per instance; frame counts run 0..71
package tfb_pkg;
   // ------------------------------------------------------------
   // Bus and decode
   // ------------------------------------------------------------
   localparam int          ADDR_W      = 12;
   localparam int          OFF_W       = 9;
   localparam logic [2:0]  FRAMER_ONE  = 3'h0;
   // ------------------------------------------------------------
   // Register indices
   // ------------------------------------------------------------
   localparam logic [8:0]  OFF_FMODE   = 9'h00f;
   localparam logic [8:0]  OFF_RXC1    = 9'h010;
   localparam logic [8:0]  OFF_RXC2    = 9'h014;
   localparam logic [8:0]  OFF_RMSG1   = 9'h064;
   localparam logic [8:0]  OFF_RMSG2   = 9'h065;
   localparam logic [8:0]  OFF_RMSG3   = 9'h066;
   localparam logic [8:0]  OFF_RX_LATCHED_STATUS_SEVEN    = 9'h096;
   localparam logic [8:0]  OFF_RIM7    = 9'h0a6;
   localparam logic [8:0]  OFF_TX_LINK_CTRL_TWO    = 9'h113;
   localparam logic [8:0]  OFF_TFBYTE  = 9'h162;
   localparam logic [8:0]  OFF_TCODE   = 9'h163;
   localparam logic [8:0]  OFF_TMSG1   = 9'h164;
   localparam logic [8:0]  OFF_TMSG2   = 9'h165;
   localparam logic [8:0]  OFF_TMSG3   = 9'h166;
   localparam logic [8:0]  OFF_TX_CONTROL_ONE    = 9'h181;
   localparam logic [8:0]  OFF_TCR2    = 9'h182;
   localparam logic [8:0]  OFF_TX_CONTROL_THREE    = 9'h183;
   localparam logic [8:0]  OFF_TX_LATCHED_STATUS_ONE    = 9'h190;
   localparam logic [8:0]  OFF_TIM1    = 9'h1a0;
   // ------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------
   localparam int          B_E1        = 0;
   localparam int          B_PASS      = 6;
   localparam int          B_TSLC      = 6;
   localparam int          B_FSSRC     = 7;
   localparam int          B_TFM       = 2;
   localparam int          B_RFM       = 5;
   localparam int          B_FBIT_CROSS_COUPLE     = 3;
   localparam int          B_SYNC_TIME_SELECT     = 7;
   localparam int          B_RSLC      = 4;
   localparam int          B_SEND      = 6;
   localparam int          B_SENT      = 4;
   localparam int          B_UPD       = 3;
   localparam logic [7:0]  REG_RST     = 8'h00;
   // ------------------------------------------------------------
   // Framing constants
   // ------------------------------------------------------------
   localparam logic [6:0]  MF_LAST     = 7'h47;
   localparam logic [5:0]  ALIGN_LEN   = 6'h0c;
   localparam logic [11:0] ALIGN_PAT   = 12'h1c7;
   localparam logic [3:0]  SF_LAST     = 4'hb;
   localparam logic [7:0]  CODE_FLAG   = 8'hff;
   localparam logic [15:0] ABORT_PAT   = 16'h00ff;
   localparam logic [3:0]  WORD_LAST   = 4'hf;
   typedef enum logic [1:0] {TFB_IDLE, TFB_SEND, TFB_ABORT} tfb_code_st_t;
endpackage : tfb_pkg

// >>> verilog/tfb_fbit_link.sv
// Purpose: T1 framing-bit data link: loop-carrier messages and codes
// Assumes: Framer strobes are synchronous one-cycle pulses
// Notes:   Avalon-MM slave with waitrequest, one wait state
`timescale 1ns/100ps
module tfb_fbit_link #(
   parameter logic [2:0] FRAMER_SEL = tfb_pkg::FRAMER_ONE
) (
   // Clock and reset
   input  wire logic                        ref_clk_in,
   input  wire logic                        arst_n_in,
   // Avalon-MM slave
   input  wire logic [tfb_pkg::ADDR_W-1:0]  avs_address_in,
   input  wire logic                        avs_read_in,
   input  wire logic                        avs_write_in,
   input  wire logic [3:0]                  avs_byteenable_in,
   input  wire logic [31:0]                 avs_writedata_in,
   output logic      [31:0]                 avs_readdata_out,
   output logic                             avs_waitrequest_out,
   output logic                             irq_out,
   // Transmit framer side
   input  wire logic                        tx_frame_strobe_in,
   input  wire logic                        tx_mf_start_in,
   input  wire logic                        tx_serial_in,
   output logic                             tx_fbit_out,
   output logic                             tx_fbit_valid_out,
   // Receive framer side
   input  wire logic                        rx_frame_strobe_in,
   input  wire logic                        rx_sf_start_in,
   input  wire logic                        rx_fbit_in,
   output logic                             rx_code_detect_en_out
);
   import tfb_pkg::*;

   logic        ack_reg;
   logic [7:0]  fmode_reg, rxc1_reg, rxc2_reg, rim7_reg, tim1_reg;
   logic [7:0]  tx_link_ctrl_two_reg, tfbyte_reg, tcode_reg, tx_control_one_reg;
   logic [7:0]  tcr2_reg, tx_control_three_reg, tx_latched_status_one_reg, rx_latched_status_seven_reg;
   logic [7:0]  tmsg_reg [3];
   logic [7:0]  rmsg_reg [3];
   logic [23:0] shadow_reg;
   logic [6:0]  fcnt_reg;
   logic        fbit_reg, fval_reg;
   logic [3:0]  bidx_reg, rpos_reg;
   logic [5:0]  bcode_reg;
   logic [35:0] rwin_reg;
   tfb_code_st_t cst_reg, cst_next;

   // ------------------------------------------------------------
   // Bus slave
   // ------------------------------------------------------------

   // Decode of one register index within this framer
   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [8:0] off);
      hit = (a[ADDR_W-1:OFF_W] == FRAMER_SEL) && (a[OFF_W-1:0] == off);
   endfunction : hit

   wire req    = avs_read_in | avs_write_in;
   wire rd_go  = avs_read_in & ack_reg;
   wire wr_go  = avs_write_in & ack_reg & avs_byteenable_in[0];
   wire [7:0] wd = avs_writedata_in[7:0];
   wire [ADDR_W-1:0] ad = avs_address_in;

   // One wait state for every access
   assign avs_waitrequest_out = req & ~ack_reg;

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) ack_reg <= 1'b0;
      else ack_reg <= req & ~ack_reg;
   end

   // Read mux; unmapped indices read zero
   logic [7:0] rmux;
   always_comb begin
      rmux = 8'h00;
      if (hit(ad, OFF_FMODE))  rmux = fmode_reg;
      if (hit(ad, OFF_RXC1))   rmux = rxc1_reg;
      if (hit(ad, OFF_RXC2))   rmux = rxc2_reg;
      if (hit(ad, OFF_RMSG1))  rmux = rmsg_reg[0];
      if (hit(ad, OFF_RMSG2))  rmux = rmsg_reg[1];
      if (hit(ad, OFF_RMSG3))  rmux = rmsg_reg[2];
      if (hit(ad, OFF_RX_LATCHED_STATUS_SEVEN))   rmux = rx_latched_status_seven_reg;
      if (hit(ad, OFF_RIM7))   rmux = rim7_reg;
      if (hit(ad, OFF_TX_LINK_CTRL_TWO))   rmux = tx_link_ctrl_two_reg;
      if (hit(ad, OFF_TFBYTE)) rmux = tfbyte_reg;
      if (hit(ad, OFF_TCODE))  rmux = tcode_reg;
      if (hit(ad, OFF_TMSG1))  rmux = tmsg_reg[0];
      if (hit(ad, OFF_TMSG2))  rmux = tmsg_reg[1];
      if (hit(ad, OFF_TMSG3))  rmux = tmsg_reg[2];
      if (hit(ad, OFF_TX_CONTROL_ONE))   rmux = tx_control_one_reg;
      if (hit(ad, OFF_TCR2))   rmux = tcr2_reg;
      if (hit(ad, OFF_TX_CONTROL_THREE))   rmux = tx_control_three_reg;
      if (hit(ad, OFF_TX_LATCHED_STATUS_ONE))   rmux = tx_latched_status_one_reg;
      if (hit(ad, OFF_TIM1))   rmux = tim1_reg;
   end

   // Read data captured while waitrequest is high
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) avs_readdata_out <= 32'h0000_0000;
      else if (avs_read_in & ~ack_reg) avs_readdata_out <= {24'h000000, rmux};
   end

   // Writable registers, framer offset decoded per instance
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         fmode_reg <= REG_RST; rxc1_reg <= REG_RST; rxc2_reg <= REG_RST;
         rim7_reg <= REG_RST; tim1_reg <= REG_RST; tx_link_ctrl_two_reg <= REG_RST;
         tfbyte_reg <= REG_RST; tcode_reg <= REG_RST; tx_control_one_reg <= REG_RST;
         tcr2_reg <= REG_RST; tx_control_three_reg <= REG_RST;
      end else if (wr_go) begin
         if (hit(ad, OFF_FMODE))  fmode_reg  <= wd;
         if (hit(ad, OFF_RXC1))   rxc1_reg   <= wd;
         if (hit(ad, OFF_RXC2))   rxc2_reg   <= wd;
         if (hit(ad, OFF_RIM7))   rim7_reg   <= wd;
         if (hit(ad, OFF_TIM1))   tim1_reg   <= wd;
         if (hit(ad, OFF_TX_LINK_CTRL_TWO))   tx_link_ctrl_two_reg   <= wd;
         if (hit(ad, OFF_TFBYTE)) tfbyte_reg <= wd;
         if (hit(ad, OFF_TCODE))  tcode_reg  <= wd;
         if (hit(ad, OFF_TX_CONTROL_ONE))   tx_control_one_reg   <= wd;
         if (hit(ad, OFF_TCR2))   tcr2_reg   <= wd;
         if (hit(ad, OFF_TX_CONTROL_THREE))   tx_control_three_reg   <= wd;
      end
   end

   // Transmit message registers, kept until rewritten
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_tmsg
         always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
            if (!arst_n_in) tmsg_reg[gi] <= REG_RST;
            else if (wr_go && hit(ad, OFF_TMSG1 + 9'(gi)))
               tmsg_reg[gi] <= wd;
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Mode decode
   // ------------------------------------------------------------
   wire t1      = ~fmode_reg[B_E1];
   wire pass    = tx_control_one_reg[B_PASS];
   wire tx_d4   = tx_control_three_reg[B_TFM];
   wire slc_on  = tcr2_reg[B_TSLC] & ~tcr2_reg[B_FSSRC];
   wire send    = tx_link_ctrl_two_reg[B_SEND];
   wire rx_d4   = rxc1_reg[B_RFM];
   wire rx_on   = t1 & rx_d4 & rxc2_reg[B_RSLC];
   wire slc_act = t1 & tx_d4 & slc_on & ~pass;

   // Receive code detector enable for the outside detector
   assign rx_code_detect_en_out = t1 & ~rx_d4;

   // ------------------------------------------------------------
   // Transmit frame position
   // ------------------------------------------------------------
   wire        tstb    = tx_frame_strobe_in;
   // Position of the strobed frame; a multiframe start forces it to 0
   wire [6:0]  tpos    = (tstb & tx_mf_start_in) ? 7'h00 : fcnt_reg;
   wire        mf_end  = tstb & (tpos == MF_LAST);
   wire        fs_frm  = tpos[0];
   wire [5:0]  fs_slot = tpos[6:1];
   wire        ft_bit  = ~tpos[1];

   // Frame counter over the 72-frame multiframe, holds the next position
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) fcnt_reg <= 7'h00;
      else if (tstb) begin
         if (tpos == MF_LAST) fcnt_reg <= 7'h00;
         else fcnt_reg <= tpos + 7'h01;
      end
   end

   // Message snapshot taken as the previous buffer completes
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) shadow_reg <= 24'h000000;
      else if (mf_end | ~slc_act)
         shadow_reg <= {tmsg_reg[2], tmsg_reg[1], tmsg_reg[0]};
   end

   // Fs content: alignment first, then 24 message bits
   wire in_align = fs_slot < ALIGN_LEN;
   wire slc_bit  = in_align ? ALIGN_PAT[4'(6'h0b - fs_slot)]
                            : shadow_reg[5'(fs_slot - ALIGN_LEN)];
   wire [2:0] sf_fs  = 3'(fs_slot % 6'h06);
   wire byte_bit = tfbyte_reg[sf_fs];

   // ------------------------------------------------------------
   // Code generator
   // ------------------------------------------------------------
   wire        fdl_tick = tstb & t1 & ~tx_d4 & ~tpos[0];
   wire [15:0] code_word = {1'b0, bcode_reg, 1'b0, CODE_FLAG};
   wire        code_bit = (cst_reg == TFB_ABORT) ? ABORT_PAT[bidx_reg]
                                                 : code_word[bidx_reg];
   wire        word_end = fdl_tick & (bidx_reg == WORD_LAST);

   // Sequencer: code words while send is set, then one abort word
   always_comb begin
      cst_next = cst_reg;
      unique case (cst_reg)
         TFB_IDLE:  if (send) cst_next = TFB_SEND;
         TFB_SEND:  if (word_end && !send) cst_next = TFB_ABORT;
         TFB_ABORT: if (word_end) cst_next = send ? TFB_SEND : TFB_IDLE;
      endcase
      if (!t1) cst_next = TFB_IDLE;
   end

   wire load_code = (cst_next == TFB_SEND) & ((cst_reg != TFB_SEND) | word_end);

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cst_reg <= TFB_IDLE;
         bidx_reg <= 4'h0;
         bcode_reg <= 6'h00;
      end else begin
         cst_reg <= cst_next;
         if (cst_next != cst_reg || cst_reg == TFB_IDLE) bidx_reg <= 4'h0;
         else if (fdl_tick) bidx_reg <= bidx_reg + 4'h1;
         if (load_code) bcode_reg <= tcode_reg[5:0];
      end
   end

   // ------------------------------------------------------------
   // Transmit F-bit selection
   // ------------------------------------------------------------
   logic fsel;
   always_comb begin
      fsel = tx_serial_in;
      if (!t1 || pass) fsel = tx_serial_in;
      else if (tx_d4) begin
         if (!fs_frm) fsel = ft_bit;
         else if (slc_act) fsel = slc_bit;
         else if (!tcr2_reg[B_FSSRC]) fsel = byte_bit;
      end else if (!tpos[0] && cst_reg != TFB_IDLE)
         fsel = code_bit;
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         fbit_reg <= 1'b0;
         fval_reg <= 1'b0;
      end else begin
         fval_reg <= tstb;
         if (tstb) fbit_reg <= fsel;
      end
   end
   assign tx_fbit_out = fbit_reg;
   assign tx_fbit_valid_out = fval_reg;

   // ------------------------------------------------------------
   // Receive loop-carrier extraction
   // ------------------------------------------------------------
   wire        rstb   = rx_frame_strobe_in;
   wire [3:0]  rpos   = (rstb & rx_sf_start_in) ? 4'h0 : rpos_reg;
   wire        rfs    = rpos[0];
   wire [35:0] rwin_n = {rwin_reg[34:0], rx_fbit_in};
   wire        rmatch = rwin_n[35:24] == ALIGN_PAT;
   wire        rchk   = rstb & (rpos == SF_LAST) & rx_on;
   wire        rload  = rchk & rmatch;
   logic [23:0] rbits;

   // First received message bit lands in bit 0 of message 1
   generate
      for (gi = 0; gi < 24; gi++) begin : g_rbit
         assign rbits[gi] = rwin_n[23-gi];
      end
   endgenerate

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rpos_reg <= 4'h0;
         rwin_reg <= 36'h0_0000_0000;
      end else if (rstb) begin
         if (rpos == SF_LAST) rpos_reg <= 4'h0;
         else rpos_reg <= rpos + 4'h1;
         if (rfs) rwin_reg <= rwin_n;
      end
   end

   generate
      for (gi = 0; gi < 3; gi++) begin : g_rmsg
         always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
            if (!arst_n_in) rmsg_reg[gi] <= REG_RST;
            else if (rload) rmsg_reg[gi] <= rbits[8*gi +: 8];
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Status and interrupt
   // ------------------------------------------------------------
   wire [7:0] tx_latched_status_one_set = {3'h0, mf_end & slc_act, 4'h0};
   wire [7:0] rx_latched_status_seven_set = {4'h0, rload, 3'h0};
   // Clear only the bits the read returned; a set in the capture cycle survives
   wire [7:0] tx_latched_status_one_clr = (rd_go && hit(ad, OFF_TX_LATCHED_STATUS_ONE)) ? avs_readdata_out[7:0] : 8'h00;
   wire [7:0] rx_latched_status_seven_clr = (rd_go && hit(ad, OFF_RX_LATCHED_STATUS_SEVEN)) ? avs_readdata_out[7:0] : 8'h00;

   // Set wins over clear-on-read
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         tx_latched_status_one_reg <= REG_RST;
         rx_latched_status_seven_reg <= REG_RST;
      end else begin
         tx_latched_status_one_reg <= (tx_latched_status_one_reg & ~tx_latched_status_one_clr) | tx_latched_status_one_set;
         rx_latched_status_seven_reg <= (rx_latched_status_seven_reg & ~rx_latched_status_seven_clr) | rx_latched_status_seven_set;
      end
   end

   assign irq_out = |(tx_latched_status_one_reg & tim1_reg) | |(rx_latched_status_seven_reg & rim7_reg);

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!arst_n_in);

   chk_mf_wrap: assert property (
      mf_end && !tx_mf_start_in |=> fcnt_reg == 7'h00)
      else $error("frame count did not wrap at 72");
   chk_align_ins: assert property (
      tstb && slc_act && fs_frm && fs_slot == 6'h00
      |=> tx_fbit_out == ALIGN_PAT[11] && tx_fbit_valid_out)
      else $error("alignment bit not inserted");
   chk_sent_flag: assert property (
      mf_end && slc_act |=> tx_latched_status_one_reg[B_SENT])
      else $error("sent flag not set at buffer end");
   chk_rx_update: assert property (
      rload |=> rx_latched_status_seven_reg[B_UPD] && rmsg_reg[0] == $past(rbits[7:0]))
      else $error("receive message not loaded");
   chk_no_align: assert property (
      $rose(rx_latched_status_seven_reg[B_UPD]) |-> $past(rchk && rmatch))
      else $error("update flag without alignment");
   chk_e1_pass: assert property (
      tstb && !t1 |=> tx_fbit_out == $past(tx_serial_in))
      else $error("E1 mode altered F bit");
   chk_pass_thru: assert property (
      tstb && pass |=> tx_fbit_out == $past(tx_serial_in))
      else $error("pass-through not honoured");
   chk_code_start: assert property (
      cst_reg == TFB_IDLE && send && t1 |=> cst_reg == TFB_SEND && bidx_reg == 4'h0)
      else $error("code send did not start");
   chk_abort_seq: assert property (
      cst_reg == TFB_SEND && word_end && !send |=> cst_reg == TFB_ABORT)
      else $error("abort not generated");
   chk_sticky_flag: assert property (
      tx_latched_status_one_reg[B_SENT] && tx_latched_status_one_clr == 8'h00 |=> tx_latched_status_one_reg[B_SENT])
      else $error("sent flag dropped without read");
   chk_one_wait: assert property (
      req && !ack_reg |=> !avs_waitrequest_out)
      else $error("bus answer late");

   cov_mf_sent: cover property (mf_end && slc_act);
   cov_rx_load: cover property (rload);
   cov_abort:   cover property (cst_reg == TFB_ABORT && word_end);
   cov_irq:     cover property ($rose(irq_out));
endmodule : tfb_fbit_link

// >>> sim/tfb_far_end.sv
// Purpose: Far-end framer stand-in for the F-bit data link block
// Assumes: One frame strobe every four clocks, 72-frame count
// Notes:   bad_align_in spoils the first alignment bit
`timescale 1ns/100ps
module tfb_far_end (
   // Clock and reset
   input  wire logic        ref_clk_in,
   input  wire logic        arst_n_in,
   // Bench control
   input  wire logic [23:0] rx_msg_in,
   input  wire logic        bad_align_in,
   // Framer side
   output logic             strobe_out,
   output logic             mf_start_out,
   output logic             sf_start_out,
   output logic             serial_out,
   output logic             rx_fbit_out,
   output logic [6:0]       frame_out
);
   import tfb_pkg::*;
   logic [1:0] div_reg;
   logic [5:0] fs_idx;
   logic       fs_bit;
   // ------------------------------------------------------------
   // Strobe timing and frame count
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         div_reg    <= 2'h0;
         frame_out  <= 7'h00;
         serial_out <= 1'b0;
      end else begin
         div_reg <= div_reg + 2'h1;
         if (strobe_out) begin
            frame_out  <= (frame_out == MF_LAST) ? 7'h00 : frame_out + 7'h01;
            serial_out <= frame_out[0] ^ frame_out[3] ^ frame_out[5];
         end
      end
   end
   // Ft alternates; Fs carries alignment then message bits
   assign strobe_out   = (div_reg == 2'h3);
   assign mf_start_out = strobe_out & (frame_out == 7'h00);
   assign sf_start_out = strobe_out & ((frame_out % 7'h0c) == 7'h00);
   assign fs_idx       = frame_out[6:1];
   assign fs_bit       = (fs_idx < 6'h0c) ?
                         (ALIGN_PAT[4'hb - fs_idx[3:0]] ^ (bad_align_in && fs_idx == 6'h00)) :
                         rx_msg_in[fs_idx - 6'h0c];
   assign rx_fbit_out  = frame_out[0] ? fs_bit : ~frame_out[1];
endmodule : tfb_far_end

// >>> sim/tb_top.sv
// Purpose: Self-checking bench for the F-bit data link block
// Assumes: One bus request at a time, one framer instance
// Notes:   Model keeps shadow messages and the expected F-bit stream
`timescale 1ns/100ps
module tb_top;
   import tfb_pkg::*;
   localparam logic [2:0] FID   = 3'h2;
   localparam int         LIMIT = 20000;
   logic        ref_clk_in, arst_n_in, avs_read_in, avs_write_in;
   logic [11:0] avs_address_in;
   logic [31:0] avs_writedata_in, avs_readdata_out;
   logic        avs_waitrequest_out, irq_out, tx_fbit, tx_valid, code_en;
   logic        strobe, mf_start, sf_start, serial, rx_fbit, bad_align, cap_ser;
   logic [6:0]  frame, cap_frame;
   logic [23:0] rx_msg, tx_msg, cur_msg;
   logic        fdl_q[$];
   int          miscompares, comparisons, cycles, mon_mode;
   tfb_fbit_link #(.FRAMER_SEL(FID)) i_dut (
      .ref_clk_in            (ref_clk_in),
      .arst_n_in             (arst_n_in),
      .avs_address_in        (avs_address_in),
      .avs_read_in           (avs_read_in),
      .avs_write_in          (avs_write_in),
      .avs_byteenable_in     (4'h1),
      .avs_writedata_in      (avs_writedata_in),
      .avs_readdata_out      (avs_readdata_out),
      .avs_waitrequest_out   (avs_waitrequest_out),
      .irq_out               (irq_out),
      .tx_frame_strobe_in    (strobe),
      .tx_mf_start_in        (mf_start),
      .tx_serial_in          (serial),
      .tx_fbit_out           (tx_fbit),
      .tx_fbit_valid_out     (tx_valid),
      .rx_frame_strobe_in    (strobe),
      .rx_sf_start_in        (sf_start),
      .rx_fbit_in            (rx_fbit),
      .rx_code_detect_en_out (code_en));
   tfb_far_end i_far (
      .ref_clk_in   (ref_clk_in),
      .arst_n_in    (arst_n_in),
      .rx_msg_in    (rx_msg),
      .bad_align_in (bad_align),
      .strobe_out   (strobe),
      .mf_start_out (mf_start),
      .sf_start_out (sf_start),
      .serial_out   (serial),
      .rx_fbit_out  (rx_fbit),
      .frame_out    (frame));
   // ------------------------------------------------------------
   // Checking and bus tasks
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic end_of_test();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_of_test
   task automatic bus(input logic is_wr, input logic [8:0] off, input logic [7:0] wd,
                      output logic [7:0] rd, input logic [2:0] fr);
      avs_address_in   <= {fr, off};
      avs_writedata_in <= {24'h0, wd};
      avs_write_in     <= is_wr;
      avs_read_in      <= !is_wr;
      @(posedge ref_clk_in iff avs_waitrequest_out === 1'b0);
      rd = avs_readdata_out[7:0];
      avs_write_in <= 1'b0;
      avs_read_in  <= 1'b0;
      @(posedge ref_clk_in);
   endtask : bus
   task automatic wr_reg(input logic [8:0] off, input logic [7:0] d, input logic [2:0] fr = FID);
      logic [7:0] junk;
      bus(1'b1, off, d, junk, fr);
   endtask : wr_reg
   task automatic rd_chk(input logic [8:0] off, input logic [7:0] exp);
      logic [7:0] v;
      bus(1'b0, off, 8'h00, v, FID);
      check(v, exp);
   endtask : rd_chk
   task automatic wait_frame(input logic [6:0] f);
      do @(posedge ref_clk_in); while (!(strobe === 1'b1 && frame === f));
   endtask : wait_frame
   task automatic collect(input int n);
      fdl_q.delete();
      mon_mode = 3;
      while (fdl_q.size() < n) @(posedge ref_clk_in);
      mon_mode = 0;
   endtask : collect
   // Expected F bit for a frame count in loop-carrier mode
   function automatic logic tx_exp(input logic [6:0] c);
      if (!c[0]) return ~c[1];
      if (c[6:1] < 6'h0c) return ALIGN_PAT[4'hb - c[4:1]];
      return cur_msg[c[6:1] - 6'h0c];
   endfunction : tx_exp
   function automatic logic has_abort();
      int run = 0;
      foreach (fdl_q[i]) begin
         run = (fdl_q[i] === 1'b0) ? run + 1 : 0;
         if (run == 8) return 1'b1;
      end
      return 1'b0;
   endfunction : has_abort
   function automatic logic word_found(input logic [15:0] w);
      logic ok;
      for (int o = 0; o < 16; o++) begin
         ok = 1'b1;
         for (int i = 0; i < 32; i++) if (fdl_q[o + i] !== w[i % 16]) ok = 1'b0;
         if (ok) return 1'b1;
      end
      return 1'b0;
   endfunction : word_found
   // ------------------------------------------------------------
   // Clock, stream monitor and timeout
   // ------------------------------------------------------------
   initial begin
      ref_clk_in = 1'b0;
      forever #12.5 ref_clk_in = ~ref_clk_in;
   end
   always @(posedge ref_clk_in) begin
      cycles++;
      if (tx_valid === 1'b1 && mon_mode == 1) check(tx_fbit, tx_exp(cap_frame));
      if (tx_valid === 1'b1 && mon_mode == 2) check(tx_fbit, cap_ser);
      if (tx_valid === 1'b1 && mon_mode == 3 && !cap_frame[0]) fdl_q.push_back(tx_fbit);
      if (strobe === 1'b1) begin
         cap_frame = frame;
         cap_ser = serial;
         if (frame == 7'h00) cur_msg = tx_msg;
      end
      if (cycles == LIMIT) begin
         miscompares++;
         end_of_test();
      end
   end
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      logic [7:0] v;
      logic [5:0] code;
      void'($urandom(32'he6eed3b2));
      {arst_n_in, avs_read_in, avs_write_in, bad_align, mon_mode} = '0;
      {avs_address_in, avs_writedata_in, rx_msg} = '0;
      repeat (2) @(posedge ref_clk_in);
      arst_n_in <= 1'b1;
      check(code_en, 1'b1);
      rd_chk(OFF_TX_LATCHED_STATUS_ONE, REG_RST);
      rd_chk(9'h1ff, 8'h00);
      tx_msg = 24'($urandom);
      code = 6'($urandom_range(63, 1));
      wr_reg(OFF_TMSG1, tx_msg[7:0]);
      wr_reg(OFF_TMSG2, tx_msg[15:8]);
      wr_reg(OFF_TMSG3, tx_msg[23:16]);
      wr_reg(OFF_TCODE, {2'h0, code});
      wr_reg(OFF_TCODE, 8'h3f, 3'h5);
      rd_chk(OFF_TCODE, {2'h0, code});
      rd_chk(OFF_TMSG3, tx_msg[23:16]);
      // Loop-carrier transmit, sent flag and interrupt
      wr_reg(OFF_TIM1, 8'h10);
      wr_reg(OFF_TX_CONTROL_THREE, 8'h04);
      wr_reg(OFF_TCR2, 8'h40);
      wait_frame(7'h00);
      mon_mode = 1;
      wait_frame(7'h00);
      check(irq_out, 1'b1);
      rd_chk(OFF_TX_LATCHED_STATUS_ONE, 8'h10);
      check(irq_out, 1'b0);
      rd_chk(OFF_TX_LATCHED_STATUS_ONE, 8'h00);
      tx_msg = 24'($urandom);
      wr_reg(OFF_TMSG1, tx_msg[7:0]);
      wr_reg(OFF_TMSG2, tx_msg[15:8]);
      wr_reg(OFF_TMSG3, tx_msg[23:16]);
      repeat (3) wait_frame(7'h00);
      mon_mode = 0;
      // Pass-through of incoming F bits
      wr_reg(OFF_TX_CONTROL_ONE, 8'h40);
      wait_frame(7'h00);
      mon_mode = 2;
      wait_frame(7'h00);
      mon_mode = 0;
      // Code word in ESF, then abort after send drops
      wr_reg(OFF_TIM1, 8'h00);
      wr_reg(OFF_TX_CONTROL_ONE, 8'h00);
      wr_reg(OFF_TX_CONTROL_THREE, 8'h00);
      wr_reg(OFF_TCR2, 8'h00);
      wr_reg(OFF_TX_LINK_CTRL_TWO, 8'h40);
      collect(48);
      check(word_found({1'b0, code, 1'b0, 8'hff}), 1'b1);
      check(has_abort(), 1'b0);
      wr_reg(OFF_TX_LINK_CTRL_TWO, 8'h00);
      collect(48);
      check(has_abort(), 1'b1);
      wr_reg(OFF_FMODE, 8'h01);
      check(code_en, 1'b0);
      wr_reg(OFF_FMODE, 8'h00);
      // Loop-carrier receive, then lost alignment
      rx_msg <= 24'($urandom) | 24'h041041; // Ones where a shifted pattern needs zeros
      wr_reg(OFF_RIM7, 8'h08);
      wr_reg(OFF_RXC1, 8'h28);
      wr_reg(OFF_RXC2, 8'h10);
      check(code_en, 1'b0);
      repeat (3) wait_frame(7'h00);
      check(irq_out, 1'b1);
      rd_chk(OFF_RX_LATCHED_STATUS_SEVEN, 8'h08);
      rd_chk(OFF_RMSG1, rx_msg[7:0]);
      rd_chk(OFF_RMSG2, rx_msg[15:8]);
      rd_chk(OFF_RMSG3, rx_msg[23:16]);
      bad_align <= 1'b1;
      wait_frame(7'h00);
      bus(1'b0, OFF_RX_LATCHED_STATUS_SEVEN, 8'h00, v, FID);
      repeat (2) wait_frame(7'h00);
      rd_chk(OFF_RX_LATCHED_STATUS_SEVEN, 8'h00);
      check(irq_out, 1'b0);
      end_of_test();
   end
endmodule : tb_top
